// *** core/rtca_calendar_alarm.v ***
/*
 holds the calendar (seconds to years) registers, the date counting with leap years, and the
 alarm compare that sets the alarm flag while irq enable is high and drives the active-low interrupt pin.
 assumes a one-cycle second tick from the time base, and a serial port front end that
 presents byte writes and reads on wr_en_i / addr_i; flag clear and irq enable come as levels.
*/
// What this block does
// - year is BCD 00..79 in bits 6..0
// - february has 29 days when year divisible by 4
// - enabled valid alarm fields compared against current time
// - all enabled fields first match sets alarm flag when irq enable is one
// - alarm event drives active-low interrupt pin
// - fields with enable zero ignored in match
// - day alarm bit 7 zero disables day compare
// - day alarm bit 7 one enables day compare
// - day alarm bits 5..0 BCD 1..31, bit 6 unused
// - 24h hour alarm bits 5..0, bit 7 enable
// - hours bit 6 selects 12h mode when one
// - weekday alarm bit 7 enables weekday compare
// - month alarm bit 7 enables month compare
`timescale 1ns/1ps
`default_nettype none
`include "rtca_map.vh"
module rtca_calendar_alarm
(
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire second_tick_i,
   input wire wr_en_i,
   input wire [5:0] addr_i,
   input wire [7:0] wr_data_i,
   output reg [7:0] rd_data_o,
   input wire alarm_irq_enable_i,
   input wire alarm_flag_clear_i,
   output reg alarm_flag_o,
   output wire int_b_o
);
   // ****************************************************************
   // helpers
   // ****************************************************************
   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == 4'h9)
         begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         end
         else
         begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
         end
      end
   endfunction

   function field_hit;
      input en;
      input [7:0] a;
      input [7:0] c;
      input [7:0] m;
      begin
         field_hit = !en || ((a & m) == (c & m));
      end
   endfunction

   // ****************************************************************
   // registers
   // ****************************************************************
   reg [7:0] cur_second;
   reg [7:0] cur_minute;
   reg [7:0] cur_hour;
   reg [7:0] cur_day;
   reg [7:0] cur_weekday;
   reg [7:0] current_month;
   reg [7:0] current_year;
   reg [7:0] alarm_second;
   reg [7:0] alarm_minute;
   reg [7:0] alarm_hour;
   reg [7:0] alarm_day;
   reg [7:0] alarm_weekday;
   reg [7:0] alarm_month;
   reg [7:0] alarm_year;
   reg match_d;

   wire mode_12h = cur_hour[`RTCA_BIT_12H];
   // leap: bcd year divisible by 4 (tens even -> units 0,4,8; odd -> 2,6)
   wire leap = current_year[4] ? (current_year[3:0] == 4'h2 || current_year[3:0] == 4'h6)
                               : (current_year[1:0] == 2'b00);
   reg [7:0] last_day;
   always @*
   begin
      case (current_month[4:0])
         5'h02: last_day = leap ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30;
         default: last_day = 8'h31;
      endcase
   end

   // ****************************************************************
   // time counting and register writes
   // ****************************************************************
   wire sec_wrap = second_tick_i && cur_second[6:0] == 7'h59;
   wire min_wrap = sec_wrap && cur_minute[6:0] == 7'h59;
   wire hr_wrap = min_wrap && (mode_12h ? (cur_hour[5:0] == 6'h31)
                                        : (cur_hour[5:0] == 6'h23));
   wire day_wrap = hr_wrap && cur_day[5:0] == last_day[5:0];
   wire mon_wrap = day_wrap && current_month[4:0] == 5'h12;
   // hour digits incremented as bcd, 12h digits without the pm bit
   wire [7:0] hour_inc_12 = bcd_inc({3'b000, cur_hour[4:0]});
   wire [7:0] hour_inc_24 = bcd_inc({2'b00, cur_hour[5:0]});
   reg [7:0] next_hour;
   always @*
   begin
      next_hour = cur_hour;
      if (mode_12h)
      begin
         if (cur_hour[4:0] == 5'h12)
         begin
            next_hour[4:0] = 5'h01;
         end
         else
         begin
            next_hour[4:0] = hour_inc_12[4:0];
            if (cur_hour[4:0] == 5'h11)
            begin
               next_hour[`RTCA_BIT_PM] = ~cur_hour[`RTCA_BIT_PM];
            end
         end
      end
      else
      begin
         next_hour[5:0] = (cur_hour[5:0] == 6'h23) ? 6'h00 : hour_inc_24[5:0];
      end
   end

   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cur_second <= `RTCA_RST_ZERO;
         cur_minute <= `RTCA_RST_ZERO;
         cur_hour <= `RTCA_RST_ZERO;
         cur_day <= `RTCA_RST_DAY;
         cur_weekday <= `RTCA_RST_WEEKDAY;
         current_month <= `RTCA_RST_MONTH;
         current_year <= `RTCA_RST_ZERO;
         alarm_second <= `RTCA_RST_ZERO;
         alarm_minute <= `RTCA_RST_ZERO;
         alarm_hour <= `RTCA_RST_ZERO;
         alarm_day <= `RTCA_RST_ZERO;
         alarm_weekday <= `RTCA_RST_ZERO;
         alarm_month <= `RTCA_RST_ZERO;
         alarm_year <= `RTCA_RST_ZERO;
      end
      else if (wr_en_i)
      begin
         // unused bits stored as zero
         case (addr_i)
            `RTCA_OFS_SECOND: cur_second <= wr_data_i & 8'h7f;
            `RTCA_OFS_MINUTE: cur_minute <= wr_data_i & 8'h7f;
            `RTCA_OFS_HOUR: cur_hour <= wr_data_i & 8'h7f;
            `RTCA_OFS_DAY: cur_day <= wr_data_i & 8'h3f;
            `RTCA_OFS_WEEKDAY: cur_weekday <= wr_data_i & 8'h07;
            `RTCA_OFS_MONTH: current_month <= wr_data_i & 8'h1f;
            `RTCA_OFS_YEAR: current_year <= wr_data_i & 8'h7f;
            `RTCA_OFS_AL_SECOND: alarm_second <= wr_data_i;
            `RTCA_OFS_AL_MINUTE: alarm_minute <= wr_data_i;
            `RTCA_OFS_AL_HOUR: alarm_hour <= wr_data_i & 8'hbf;
            `RTCA_OFS_AL_DAY: alarm_day <= wr_data_i & 8'hbf;
            `RTCA_OFS_AL_WEEKDAY: alarm_weekday <= wr_data_i & 8'h87;
            `RTCA_OFS_AL_MONTH: alarm_month <= wr_data_i & 8'h9f;
            `RTCA_OFS_AL_YEAR: alarm_year <= wr_data_i;
            default: ;
         endcase
      end
      else if (second_tick_i)
      begin
         cur_second <= sec_wrap ? 8'h00 : bcd_inc(cur_second);
         if (sec_wrap)
         begin
            cur_minute <= min_wrap ? 8'h00 : bcd_inc(cur_minute);
         end
         if (min_wrap)
         begin
            cur_hour <= next_hour;
         end
         if (hr_wrap)
         begin
            cur_day <= day_wrap ? 8'h01 : bcd_inc(cur_day);
            cur_weekday <= (cur_weekday[2:0] == 3'h7) ? 8'h01 : bcd_inc(cur_weekday);
         end
         if (day_wrap)
         begin
            current_month <= mon_wrap ? 8'h01 : bcd_inc(current_month);
         end
         if (mon_wrap)
         begin
            current_year <= (current_year[6:0] == 7'h79) ? 8'h00 : bcd_inc(current_year);
         end
      end
   end

   // ****************************************************************
   // alarm compare
   // ****************************************************************
   // bit 5 is tens of hours in 24h mode and the pm indicator in 12h mode
   wire [7:0] hour_mask = 8'h3f;
   wire any_en = alarm_second[7] | alarm_minute[7] | alarm_hour[7] | alarm_day[7] |
                 alarm_weekday[7] | alarm_month[7] | alarm_year[7];
   wire all_match = any_en &&
      field_hit(alarm_second[7], alarm_second, cur_second, 8'h7f) &&
      field_hit(alarm_minute[7], alarm_minute, cur_minute, 8'h7f) &&
      field_hit(alarm_hour[7], alarm_hour, cur_hour, hour_mask) &&
      field_hit(alarm_day[`RTCA_BIT_ENABLE], alarm_day, cur_day, 8'h3f) &&
      field_hit(alarm_weekday[7], alarm_weekday, cur_weekday, 8'h07) &&
      field_hit(alarm_month[7], alarm_month, current_month, 8'h1f) &&
      field_hit(alarm_year[7], alarm_year, current_year, 8'h7f);
   wire alarm_event = all_match && !match_d;

   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         match_d <= 1'b0;
         alarm_flag_o <= 1'b0;
      end
      else
      begin
         match_d <= all_match;
         if (alarm_event && alarm_irq_enable_i)
         begin
            alarm_flag_o <= 1'b1; // set wins over clear
         end
         else if (alarm_flag_clear_i)
         begin
            alarm_flag_o <= 1'b0;
         end
      end
   end

   assign int_b_o = ~(alarm_flag_o & alarm_irq_enable_i);

   // ****************************************************************
   // read back
   // ****************************************************************
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rd_data_o <= 8'h00;
      end
      else
      begin
         case (addr_i)
            `RTCA_OFS_SECOND: rd_data_o <= cur_second;
            `RTCA_OFS_MINUTE: rd_data_o <= cur_minute;
            `RTCA_OFS_HOUR: rd_data_o <= cur_hour;
            `RTCA_OFS_DAY: rd_data_o <= cur_day;
            `RTCA_OFS_WEEKDAY: rd_data_o <= cur_weekday;
            `RTCA_OFS_MONTH: rd_data_o <= current_month;
            `RTCA_OFS_YEAR: rd_data_o <= current_year;
            `RTCA_OFS_AL_SECOND: rd_data_o <= alarm_second;
            `RTCA_OFS_AL_MINUTE: rd_data_o <= alarm_minute;
            `RTCA_OFS_AL_HOUR: rd_data_o <= alarm_hour;
            `RTCA_OFS_AL_DAY: rd_data_o <= alarm_day;
            `RTCA_OFS_AL_WEEKDAY: rd_data_o <= alarm_weekday;
            `RTCA_OFS_AL_MONTH: rd_data_o <= alarm_month;
            `RTCA_OFS_AL_YEAR: rd_data_o <= alarm_year;
            default: rd_data_o <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** pkg/rtca_map.vh ***
/*
 holds register offsets, field positions and reset values of the calendar and alarm block.
 assumes it is included by its bare name from the design file.
*/
`ifndef RTCA_MAP_VH
`define RTCA_MAP_VH
`define RTCA_OFS_SECOND 6'h08
`define RTCA_OFS_MINUTE 6'h09
`define RTCA_OFS_HOUR 6'h0a
`define RTCA_OFS_DAY 6'h0b
`define RTCA_OFS_WEEKDAY 6'h0c
`define RTCA_OFS_MONTH 6'h0d
`define RTCA_OFS_YEAR 6'h0e
`define RTCA_OFS_AL_SECOND 6'h10
`define RTCA_OFS_AL_MINUTE 6'h11
`define RTCA_OFS_AL_HOUR 6'h12
`define RTCA_OFS_AL_DAY 6'h13
`define RTCA_OFS_AL_WEEKDAY 6'h14
`define RTCA_OFS_AL_MONTH 6'h15
`define RTCA_OFS_AL_YEAR 6'h16
`define RTCA_BIT_ENABLE 7
`define RTCA_BIT_12H 6
`define RTCA_BIT_PM 5
`define RTCA_RST_MONTH 8'h01
`define RTCA_RST_DAY 8'h01
`define RTCA_RST_WEEKDAY 8'h01
`define RTCA_RST_ZERO 8'h00
`endif

// *** testbench/rtca_chk.sv ***
/* port checker of the calendar alarm block.
 assumes one clock and the bind below. */
`timescale 1ns/1ps
`default_nettype none
module rtca_chk
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic wr_en_i,
   input wire logic [5:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [7:0] rd_data_o,
   input wire logic alarm_irq_enable_i,
   input wire logic alarm_flag_clear_i,
   input wire logic alarm_flag_o,
   input wire logic int_b_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   AST_INT_PIN: assert property (int_b_o == !(alarm_flag_o && alarm_irq_enable_i))
      else $error("pin disagrees with flag");
   AST_SET_NEEDS_IRQ: assert property ($rose(alarm_flag_o) |-> $past(alarm_irq_enable_i))
      else $error("flag set without irq enable");
   AST_FLAG_HOLD: assert property (alarm_flag_o && !alarm_flag_clear_i |=> alarm_flag_o)
      else $error("flag dropped without clear");
   AST_CLEAR: assert property (alarm_flag_clear_i && !alarm_irq_enable_i |=> !alarm_flag_o)
      else $error("flag not cleared");
   AST_NO_IRQ_STAY: assert property (!alarm_irq_enable_i && !alarm_flag_o |=> !alarm_flag_o)
      else $error("flag rose with irq disabled");
   AST_YEAR_BIT7: assert property (addr_i == 6'h0e |=> !rd_data_o[7])
      else $error("year bit 7 set");
   AST_DAY_BIT6: assert property (addr_i == 6'h13 |=> !rd_data_o[6])
      else $error("day alarm bit 6 set");
   AST_HOUR_BIT6: assert property (addr_i == 6'h12 |=> !rd_data_o[6])
      else $error("hour alarm bit 6 set");
   AST_YEAR_WR: assert property (wr_en_i && addr_i == 6'h0e ##1 !wr_en_i && addr_i == 6'h0e
      |=> rd_data_o == ($past(wr_data_i, 2) & 8'h7f))
      else $error("year readback wrong");
endmodule
bind rtca_calendar_alarm rtca_chk rtca_chk_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
   .wr_en_i(wr_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
   .alarm_irq_enable_i(alarm_irq_enable_i), .alarm_flag_clear_i(alarm_flag_clear_i),
   .alarm_flag_o(alarm_flag_o), .int_b_o(int_b_o));
`default_nettype wire

// *** testbench/rtca_host_model.sv ***
/* host side model: counts alarm interrupts seen on the active-low pin.
 assumes the pin is sampled on the block clock. */
`timescale 1ns/1ps
`default_nettype none
module rtca_host_model
(
   input wire logic sys_clk_i,
   input wire logic int_b_i,
   output logic [7:0] irq_count_o
);
   logic int_b_d = 1'b1;
   initial irq_count_o = 8'h00;
   // count each falling edge of the pin
   always @(posedge sys_clk_i)
   begin
      int_b_d <= int_b_i;
      if (int_b_d && !int_b_i)
         irq_count_o <= irq_count_o + 8'h01;
   end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
/* bench of the calendar alarm block: register access, leap days, alarm compare.
 assumes the host model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic tick = 1'b0;
   logic wen = 1'b0;
   logic irq_en = 1'b0;
   logic clr = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [7:0] wdat = 8'h00;
   wire logic [7:0] rdat;
   wire logic flag;
   wire logic int_b;
   wire logic [7:0] nirq;
   int err_total = 0;
   int n_checks = 0;
   rtca_calendar_alarm rtca_calendar_alarm_inst (.sys_clk_i(clk), .rst_b_i(rst_b),
      .second_tick_i(tick), .wr_en_i(wen), .addr_i(addr), .wr_data_i(wdat), .rd_data_o(rdat),
      .alarm_irq_enable_i(irq_en), .alarm_flag_clear_i(clr), .alarm_flag_o(flag), .int_b_o(int_b));
   rtca_host_model rtca_host_model_inst (.sys_clk_i(clk), .int_b_i(int_b), .irq_count_o(nirq));
   initial
   begin
      forever #25 clk = ~clk;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: byte %h not %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: bit %b not %b", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      wen <= 1'b1;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      wen <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      @(negedge clk);
      chk8(rdat, exp);
   endtask
   task automatic pulse_tick();
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
   endtask
   task automatic clear();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask
   // seconds 04 then one tick to 05, where the second alarm waits
   task automatic fire(input logic exp);
      wr(6'h08, 8'h04);
      pulse_tick();
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk1(flag, exp);
   endtask
   // last second of 28 february of year y
   task automatic leap(input logic [7:0] y, input logic [7:0] exp_day);
      wr(6'h0e, y);
      wr(6'h0d, 8'h02);
      wr(6'h0b, 8'h28);
      wr(6'h0a, 8'h23);
      wr(6'h09, 8'h59);
      wr(6'h08, 8'h59);
      pulse_tick();
      rd(6'h0b, exp_day);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      report_and_stop();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      chk1(int_b, 1'b1);
      rd(6'h0e, 8'h00);
      wr(6'h0e, 8'h79);
      rd(6'h0e, 8'h79);
      wr(6'h13, 8'hf1);
      rd(6'h13, 8'hb1);
      wr(6'h12, 8'hc5);
      rd(6'h12, 8'h85);
      leap(8'h00, 8'h29);
      leap(8'h04, 8'h29);
      leap(8'h03, 8'h01);
      rd(6'h0d, 8'h03);
      wr(6'h13, 8'h15);
      wr(6'h12, 8'h00);
      @(posedge clk);
      irq_en <= 1'b1;
      wr(6'h10, 8'h85);
      fire(1'b1);
      chk1(int_b, 1'b0);
      clear();
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk1(flag, 1'b0);
      wr(6'h13, 8'h95);
      fire(1'b0);
      wr(6'h0b, 8'h15);
      fire(1'b1);
      clear();
      wr(6'h15, 8'h84);
      fire(1'b0);
      wr(6'h15, 8'h03);
      fire(1'b1);
      clear();
      wr(6'h0c, 8'h03);
      wr(6'h14, 8'h85);
      fire(1'b0);
      wr(6'h14, 8'h83);
      fire(1'b1);
      clear();
      wr(6'h0a, 8'h15);
      wr(6'h12, 8'h94);
      fire(1'b0);
      wr(6'h12, 8'h95);
      fire(1'b1);
      @(posedge clk);
      irq_en <= 1'b0;
      clear();
      fire(1'b0);
      chk1(int_b, 1'b1);
      wr(6'h0a, 8'h41);
      wr(6'h12, 8'ha1);
      @(posedge clk);
      irq_en <= 1'b1;
      fire(1'b0);
      wr(6'h0a, 8'h61);
      fire(1'b1);
      chk8(nirq, 8'h06);
      report_and_stop();
   end
endmodule
`default_nettype wire
